// ===== verilog/nfbi_top.v
`timescale 1ns/1ns
`include "nfbi_regs.vh"

// Overview of operation
// - upper address bits pick the block
// - address latch transparent while address valid low
// - read drives selected data onto sixteen lines
// - sync read captures address at first edge
// - wait marks invalid sync data, polarity configurable
// - wait deasserted in async reads and writes
// - write latches at first rising strobe edge
// - output enable high floats data and wait
// - deselect floats outputs regardless of output enable
// - deselect does not stop running operation
// - reset exit gives array mode, status 0x80
// - reset floats outputs, ignores controls, stops work
// - reset during program or erase aborts it
// - commands enter through unmapped command port
// - 0xff selects array read mode
// - 0x70 selects status read on low byte
// - program or erase commands select status mode
// - 0x90 selects identifier read mode
module nfbi_top #(
    parameter ADDR_W = 26,
    parameter BLK_W = 9,
    parameter [3:0] SYNC_LAT = `NFBI_SYNC_LAT,
    parameter [15:0] MFR_CODE = 16'h00a5, // arbitrary value
    parameter [15:0] DEV_CODE = 16'h005a // arbitrary value
) (
    input wire CLK_I,
    input wire RESET_N_I,
    input wire FCLK_I,
    input wire ADDR_VALID_N_I,
    input wire CE_N_I,
    input wire OE_N_I,
    input wire WE_N_I,
    input wire [ADDR_W-1:0] ADDR_I,
    input wire [15:0] DQ_I,
    input wire [15:0] READ_CFG_I,
    input wire [15:0] ARRAY_DATA_I,
    input wire OP_BUSY_I,
    input wire [6:0] OP_FLAGS_I,
    output reg [15:0] DQ_O,
    output reg DQ_OE_O,
    output reg WAIT_O,
    output reg WAIT_OE_O,
    output reg [ADDR_W-1:0] ARRAY_ADDR_O,
    output reg ARRAY_RD_O,
    output reg [BLK_W-1:0] BLOCK_O,
    output wire OP_START_O,
    output wire [7:0] OP_CMD_O,
    output wire [ADDR_W-1:0] OP_ADDR_O,
    output wire [15:0] OP_DATA_O,
    output reg OP_ABORT_O
);

    // ----------------------------------------
    // pin samples and edge history
    // ----------------------------------------
    reg addr_valid_n_reg, ce_n_reg, oe_n_reg, we_n_reg, fclk_reg;
    reg addr_valid_prev_reg, fclk_prev_reg, wr_prev_reg;
    reg [ADDR_W-1:0] addr_reg;
    reg [15:0] dq_reg;

    // pins treated as synchronous; reset flops take constants only
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            addr_valid_n_reg <= 1'b1;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            fclk_reg <= 1'b0;
            addr_valid_prev_reg <= 1'b1;
            fclk_prev_reg <= 1'b0;
            addr_reg <= {ADDR_W{1'b0}};
            dq_reg <= 16'h0000;
        end else begin
            addr_valid_n_reg <= ADDR_VALID_N_I;
            ce_n_reg <= CE_N_I;
            oe_n_reg <= OE_N_I;
            we_n_reg <= WE_N_I;
            fclk_reg <= FCLK_I;
            addr_valid_prev_reg <= addr_valid_n_reg;
            fclk_prev_reg <= fclk_reg;
            addr_reg <= ADDR_I;
            dq_reg <= DQ_I;
        end
    end

    // ----------------------------------------
    // bus operation decode
    // ----------------------------------------
    wire sel = ~ce_n_reg;
    wire rd_act = sel & ~oe_n_reg & we_n_reg;
    wire wr_act = sel & ~we_n_reg & oe_n_reg;
    wire wr_end = wr_prev_reg & ~wr_act;
    wire fclk_rise = fclk_reg & ~fclk_prev_reg;
    wire addr_valid_rise = addr_valid_n_reg & ~addr_valid_prev_reg;
    wire addr_valid_fall = ~addr_valid_n_reg & addr_valid_prev_reg;
    wire wait_pol = READ_CFG_I[`NFBI_CFG_WAIT_POL_BIT];

    // ----------------------------------------
    // address latch and synchronous burst tracking
    // ----------------------------------------
    reg [ADDR_W-1:0] addr_lat_reg;
    reg [ADDR_W-1:0] burst_addr_reg;
    reg sync_cap_reg, burst_reg;
    reg [3:0] lat_cnt_reg;
    reg [15:0] wr_data_reg;
    wire sync_start = fclk_rise & ~addr_valid_n_reg & sel & ~sync_cap_reg;
    wire [ADDR_W-1:0] rd_addr = burst_reg ? burst_addr_reg : addr_lat_reg;
    wire wait_busy = burst_reg & (lat_cnt_reg < SYNC_LAT);

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            addr_lat_reg <= {ADDR_W{1'b0}};
            burst_addr_reg <= {ADDR_W{1'b0}};
            sync_cap_reg <= 1'b0;
            burst_reg <= 1'b0;
            lat_cnt_reg <= 4'h0;
            wr_prev_reg <= 1'b0;
            wr_data_reg <= 16'h0000;
        end else begin
            // transparent until a clock edge freezes it
            if (~addr_valid_n_reg & ~sync_cap_reg) begin
                addr_lat_reg <= addr_reg;
            end
            if (~sel | addr_valid_rise) begin
                sync_cap_reg <= 1'b0;
            end else if (sync_start) begin
                sync_cap_reg <= 1'b1;
            end
            if (~sel) begin
                burst_reg <= 1'b0;
                lat_cnt_reg <= 4'h0;
            end else if (sync_start) begin
                // a capture wins over a fall seen in the same cycle
                burst_reg <= 1'b1;
                burst_addr_reg <= addr_reg;
                lat_cnt_reg <= 4'h0;
            end else if (addr_valid_fall) begin
                burst_reg <= 1'b0;
                lat_cnt_reg <= 4'h0;
            end else if (burst_reg & fclk_rise) begin
                if (lat_cnt_reg < SYNC_LAT) begin
                    lat_cnt_reg <= lat_cnt_reg + 4'h1;
                end else begin
                    burst_addr_reg <= burst_addr_reg + {{(ADDR_W-1){1'b0}}, 1'b1};
                end
            end
            // data held from the last cycle before the strobe rises
            wr_prev_reg <= wr_act;
            if (wr_act) begin
                wr_data_reg <= dq_reg;
            end
        end
    end

    // ----------------------------------------
    // command port
    // ----------------------------------------
    wire [1:0] mode;

    nfbi_cmd #(
        .ADDR_W(ADDR_W)
    ) u_cmd (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .wr_stb_i(wr_end),
        .wr_addr_i(addr_lat_reg),
        .wr_data_i(wr_data_reg),
        .mode_o(mode),
        .op_start_o(OP_START_O),
        .op_cmd_o(OP_CMD_O),
        .op_addr_o(OP_ADDR_O),
        .op_data_o(OP_DATA_O)
    );

    // ----------------------------------------
    // status register
    // ----------------------------------------
    reg [7:0] status_reg;

    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            status_reg <= `NFBI_SR_RESET;
            OP_ABORT_O <= 1'b1;
        end else begin
            status_reg[`NFBI_SR_READY_BIT] <= ~OP_BUSY_I;
            status_reg[6:0] <= OP_FLAGS_I;
            OP_ABORT_O <= 1'b0;
        end
    end

    // ----------------------------------------
    // read data selection
    // ----------------------------------------
    reg [15:0] id_word;
    reg [15:0] dq_next;

    always @* begin
        case (rd_addr[7:0])
            `NFBI_ID_MFR_OFS: id_word = MFR_CODE;
            `NFBI_ID_DEV_OFS: id_word = DEV_CODE;
            `NFBI_ID_CFG_OFS: id_word = READ_CFG_I;
            default: id_word = 16'h0000;
        endcase
        case (mode)
            `NFBI_MODE_ARRAY: dq_next = ARRAY_DATA_I;
            `NFBI_MODE_STATUS: dq_next = {8'h00, status_reg};
            `NFBI_MODE_ID: dq_next = id_word;
            default: dq_next = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // registered pin drivers
    // ----------------------------------------
    always @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            DQ_O <= 16'h0000;
            DQ_OE_O <= 1'b0;
            WAIT_O <= 1'b0;
            WAIT_OE_O <= 1'b0;
            ARRAY_ADDR_O <= {ADDR_W{1'b0}};
            ARRAY_RD_O <= 1'b0;
            BLOCK_O <= {BLK_W{1'b0}};
        end else begin
            DQ_O <= rd_act ? dq_next : 16'h0000;
            DQ_OE_O <= rd_act;
            WAIT_OE_O <= sel & ~oe_n_reg;
            // asserted level equals the polarity bit
            if (rd_act & wait_busy) begin
                WAIT_O <= wait_pol;
            end else begin
                WAIT_O <= ~wait_pol;
            end
            ARRAY_ADDR_O <= rd_addr;
            ARRAY_RD_O <= rd_act & (mode == `NFBI_MODE_ARRAY);
            BLOCK_O <= rd_addr[ADDR_W-1 -: BLK_W];
        end
    end

endmodule

// ===== include/nfbi_regs.vh
`ifndef NFBI_REGS_VH
`define NFBI_REGS_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define NFBI_CMD_READ_ARRAY 8'hff
`define NFBI_CMD_READ_STATUS 8'h70
`define NFBI_CMD_READ_ID 8'h90
`define NFBI_CMD_WORD_PGM 8'h40
`define NFBI_CMD_BUF_PGM 8'he8
`define NFBI_CMD_FACT_PGM 8'h80
`define NFBI_CMD_BLK_ERASE 8'h20

// ----------------------------------------
// read modes
// ----------------------------------------
`define NFBI_MODE_ARRAY 2'h0
`define NFBI_MODE_STATUS 2'h1
`define NFBI_MODE_ID 2'h2

// ----------------------------------------
// status, configuration and identifier layout
// ----------------------------------------
`define NFBI_SR_RESET 8'h80
`define NFBI_SR_READY_BIT 7
`define NFBI_CFG_WAIT_POL_BIT 10
`define NFBI_ID_MFR_OFS 8'h00
`define NFBI_ID_DEV_OFS 8'h01
`define NFBI_ID_CFG_OFS 8'h05

// ----------------------------------------
// timing counts
// ----------------------------------------
`define NFBI_SYNC_LAT 4'h4

`endif

// ===== verilog/nfbi_cmd.v
`timescale 1ns/1ns
`include "nfbi_regs.vh"

module nfbi_cmd #(
    parameter ADDR_W = 26
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire wr_stb_i,
    input wire [ADDR_W-1:0] wr_addr_i,
    input wire [15:0] wr_data_i,
    output reg [1:0] mode_o,
    output reg op_start_o,
    output reg [7:0] op_cmd_o,
    output reg [ADDR_W-1:0] op_addr_o,
    output reg [15:0] op_data_o
);

    reg setup_reg;
    reg [7:0] setup_code_reg;
    wire [7:0] code = wr_data_i[7:0]; // low byte is the command

    // ----------------------------------------
    // command decode on each latched write
    // ----------------------------------------
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_o <= `NFBI_MODE_ARRAY;
            op_start_o <= 1'b0;
            op_cmd_o <= 8'h00;
            op_addr_o <= {ADDR_W{1'b0}};
            op_data_o <= 16'h0000;
            setup_reg <= 1'b0;
            setup_code_reg <= 8'h00;
        end else begin
            op_start_o <= 1'b0;
            if (wr_stb_i) begin
                if (setup_reg) begin
                    // second cycle hands the operation to the engine
                    setup_reg <= 1'b0;
                    op_start_o <= 1'b1;
                    op_cmd_o <= setup_code_reg;
                    op_addr_o <= wr_addr_i;
                    op_data_o <= wr_data_i;
                end else begin
                    case (code)
                        `NFBI_CMD_READ_ARRAY: mode_o <= `NFBI_MODE_ARRAY;
                        `NFBI_CMD_READ_STATUS: mode_o <= `NFBI_MODE_STATUS;
                        `NFBI_CMD_READ_ID: mode_o <= `NFBI_MODE_ID;
                        `NFBI_CMD_WORD_PGM, `NFBI_CMD_BUF_PGM, `NFBI_CMD_FACT_PGM, `NFBI_CMD_BLK_ERASE: begin
                            mode_o <= `NFBI_MODE_STATUS;
                            setup_reg <= 1'b1;
                            setup_code_reg <= code;
                        end
                        default: mode_o <= mode_o;
                    endcase
                end
            end
        end
    end

endmodule

// ===== verif/nfbi_array_model.sv
`timescale 1ns/1ns
// array behind the read port: word is a fixed scramble of the address
module nfbi_array_model #(parameter ADDR_W = 26) (
    input wire [ADDR_W-1:0] addr_i,
    output wire [15:0] data_o
);
    assign data_o = addr_i[15:0] ^ 16'h5a3c;
endmodule

// ===== verif/nfbi_top_properties.sv
`timescale 1ns/1ns
module nfbi_chk #(parameter ADDR_W = 26, parameter BLK_W = 9) (
    input wire CLK_I,
    input wire RESET_N_I,
    input wire FCLK_I,
    input wire ADDR_VALID_N_I,
    input wire CE_N_I,
    input wire OE_N_I,
    input wire WE_N_I,
    input wire [ADDR_W-1:0] ADDR_I,
    input wire [15:0] DQ_I,
    input wire [15:0] READ_CFG_I,
    input wire DQ_OE_O,
    input wire WAIT_O,
    input wire WAIT_OE_O,
    input wire [ADDR_W-1:0] ARRAY_ADDR_O,
    input wire ARRAY_RD_O,
    input wire [BLK_W-1:0] BLOCK_O,
    input wire OP_START_O,
    input wire OP_ABORT_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    // write cycle carrying the status command
    sequence stat_wr;
        (!CE_N_I && !WE_N_I && OE_N_I && DQ_I[7:0] == 8'h70) ##1 WE_N_I;
    endsequence
    // any clock rise seen with address valid low, not only the first
    sequence burst_go;
        (!ADDR_VALID_N_I && !CE_N_I && !OE_N_I && !FCLK_I) ##1 (FCLK_I && !ADDR_VALID_N_I && !CE_N_I && !OE_N_I);
    endsequence
    chk_read_drive: assert property (!CE_N_I && !OE_N_I && WE_N_I |-> ##2 DQ_OE_O)
        else $error("read not driven");
    chk_oe_float: assert property (OE_N_I |-> ##2 (!DQ_OE_O && !WAIT_OE_O))
        else $error("driving with output enable off");
    chk_standby_float: assert property (CE_N_I |-> ##2 (!DQ_OE_O && !WAIT_OE_O))
        else $error("driving while deselected");
    chk_write_nowait: assert property (!CE_N_I && !WE_N_I |-> ##2 (WAIT_O == !READ_CFG_I[10]))
        else $error("wait asserted in write");
    chk_burst_wait: assert property (burst_go |-> ##3 (WAIT_O == READ_CFG_I[10] && WAIT_OE_O)[*2])
        else $error("wait not asserted at burst start");
    chk_addr_latch: assert property ((!ADDR_VALID_N_I && !CE_N_I && !OE_N_I && !FCLK_I && $stable(ADDR_I))[*3]
        |-> (ARRAY_ADDR_O == ADDR_I && BLOCK_O == ADDR_I[ADDR_W-1 -: BLK_W]))
        else $error("address latch not transparent");
    chk_reset_float: assert property (disable iff (1'b0) (!RESET_N_I)[*2]
        |-> (!DQ_OE_O && !WAIT_OE_O && !OP_START_O && OP_ABORT_O))
        else $error("outputs active in reset");
    chk_abort_clear: assert property (RESET_N_I && $past(RESET_N_I) |-> !OP_ABORT_O)
        else $error("abort held after reset");
    chk_status_mode: assert property (stat_wr |-> ##1 (!ARRAY_RD_O)[*4])
        else $error("array read after status command");
    chk_start_pulse: assert property (OP_START_O |=> !OP_START_O)
        else $error("start longer than one cycle");
endmodule

bind nfbi_top nfbi_chk #(.ADDR_W(ADDR_W), .BLK_W(BLK_W)) u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .FCLK_I(FCLK_I), .ADDR_VALID_N_I(ADDR_VALID_N_I), .CE_N_I(CE_N_I), .OE_N_I(OE_N_I), .WE_N_I(WE_N_I),
    .ADDR_I(ADDR_I),
    .DQ_I(DQ_I), .READ_CFG_I(READ_CFG_I), .DQ_OE_O(DQ_OE_O), .WAIT_O(WAIT_O), .WAIT_OE_O(WAIT_OE_O),
    .ARRAY_ADDR_O(ARRAY_ADDR_O), .ARRAY_RD_O(ARRAY_RD_O), .BLOCK_O(BLOCK_O), .OP_START_O(OP_START_O),
    .OP_ABORT_O(OP_ABORT_O));

// ===== verif/tb_nor_flash_bus_interface.sv
`timescale 1ns/1ns
`include "nfbi_regs.vh"
module tb_nor_flash_bus_interface;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg fclk = 1'b0;
    reg [3:0] ctl = 4'hf; // addr valid, ce, oe, we (all active low)
    reg [25:0] addr = 26'h0;
    reg [25:0] a = 26'h0;
    reg [15:0] dq = 16'h0;
    reg [15:0] cfg = 16'h0;
    reg [15:0] w = 16'h0;
    reg [31:0] mcodes = 32'h709050ff;
    reg [31:0] pcodes = 32'h40e88020;
    reg busy = 1'b0;
    reg [6:0] flags = 7'h0;
    reg [1:0] mode = 2'h0;
    reg [49:0] got = 50'h0;
    wire [15:0] dq_o, arr, op_d;
    wire dq_oe, wait_pin, wait_oe, rd, start, abort;
    wire [25:0] aa, op_a;
    wire [8:0] blk;
    wire [7:0] op_c;
    integer n_errors = 0, n_tests = 0, seed = 32'h6f76, cyc = 0, n_start = 0, i;
    always #5 clk = ~clk;
    nfbi_top dut (.CLK_I(clk), .RESET_N_I(rst_n), .FCLK_I(fclk), .ADDR_VALID_N_I(ctl[3]), .CE_N_I(ctl[2]),
        .OE_N_I(ctl[1]), .WE_N_I(ctl[0]), .ADDR_I(addr), .DQ_I(dq), .READ_CFG_I(cfg), .ARRAY_DATA_I(arr),
        .OP_BUSY_I(busy), .OP_FLAGS_I(flags), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .WAIT_O(wait_pin),
        .WAIT_OE_O(wait_oe),
        .ARRAY_ADDR_O(aa), .ARRAY_RD_O(rd), .BLOCK_O(blk), .OP_START_O(start), .OP_CMD_O(op_c),
        .OP_ADDR_O(op_a), .OP_DATA_O(op_d), .OP_ABORT_O(abort));
    nfbi_array_model u_arr (.addr_i(aa), .data_o(arr));
    // cycle ceiling and capture of started operations
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (start === 1'b1) begin
            n_start = n_start + 1;
            got = {op_c, op_a, op_d};
        end
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            finish_test;
        end
    end
    task finish_test;
        begin
            $display("tests %0d mismatches %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task chk(input [127:0] name, input [63:0] seen, input [63:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("BAD %0s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // read data the bus should return in the current mode
    function [15:0] exp_rd(input [25:0] ad);
        case (mode)
            `NFBI_MODE_STATUS: exp_rd = {8'h00, ~busy, flags};
            `NFBI_MODE_ID: exp_rd = ad[7:0] == 8'h00 ? 16'h00a5 : ad[7:0] == 8'h01 ? 16'h005a :
                ad[7:0] == 8'h05 ? cfg : 16'h0000;
            default: exp_rd = ad[15:0] ^ 16'h5a3c;
        endcase
    endfunction
    task bus_rd(input [25:0] ad);
        begin
            addr = ad;
            ctl = 4'b0001;
            tick(4);
            chk("rd_oe", dq_oe, 1);
            chk("rd_data", dq_o, exp_rd(ad));
            chk("rd_block", blk, ad[25:17]);
            chk("rd_array", rd, mode == `NFBI_MODE_ARRAY);
            chk("rd_wait", wait_pin, !cfg[10]);
            ctl = 4'b1111;
            tick(3);
            chk("rd_float", dq_oe, 0);
        end
    endtask
    task bus_wr(input [25:0] ad, input [15:0] d);
        begin
            addr = ad;
            dq = d;
            ctl = 4'b0010;
            tick(3);
            ctl = 4'b1111;
            tick(3);
            case (d[7:0])
                8'hff: mode = `NFBI_MODE_ARRAY;
                8'h90: mode = `NFBI_MODE_ID;
                8'h70, 8'h40, 8'he8, 8'h80, 8'h20: mode = `NFBI_MODE_STATUS;
                default: ;
            endcase
        end
    endtask
    initial begin
        tick(4);
        rst_n = 1'b1;
        tick(2);
        // mode commands, one unknown code, reads at id offsets
        for (i = 0; i < 12; i = i + 1) begin
            busy = $random(seed);
            flags = $random(seed);
            cfg = $random(seed);
            w = $random(seed);
            a = $random(seed);
            bus_wr(a, {w[15:8], mcodes[8 * (i % 4) +: 8]});
            bus_rd({a[25:8], 8'h00});
            bus_rd({a[25:8], i[7:0] - 8'h01});
        end
        $display("mode test done");
        // every setup code followed by its data write
        for (i = 0; i < 4; i = i + 1) begin
            n_start = 0;
            bus_wr($random(seed), {8'h5c, pcodes[8 * i +: 8]});
            a = $random(seed);
            w = $random(seed) & 32'hff00;
            bus_wr(a, w);
            chk("op_count", n_start, 1);
            chk("op_info", got, {pcodes[8 * i +: 8], a, w});
            bus_rd(a);
            chk("op_abort", abort, 0);
        end
        $display("program test done");
        // reset in the middle of a status read
        ctl = 4'b0001;
        tick(3);
        rst_n = 1'b0;
        tick(2);
        chk("rst_oe", dq_oe, 0);
        chk("rst_abort", abort, 1);
        ctl = 4'b1111;
        rst_n = 1'b1;
        mode = `NFBI_MODE_ARRAY;
        tick(2);
        bus_rd($random(seed));
        $display("reset test done");
        // burst reads in both wait polarities
        for (i = 0; i < 2; i = i + 1) begin
            cfg = {5'h00, i[0], 10'h000};
            addr = $random(seed);
            ctl = 4'b0001;
            tick(2);
            fclk = 1'b1;
            tick(2);
            fclk = 1'b0;
            ctl = 4'b1001;
            tick(2);
            chk("burst_wait", {wait_oe, wait_pin}, {1'b1, i[0]});
            repeat (6) begin
                fclk = 1'b1;
                tick(2);
                fclk = 1'b0;
                tick(2);
            end
            chk("burst_ready", wait_pin, !i[0]);
            ctl = 4'b1111;
            tick(3);
        end
        $display("burst test done");
        finish_test;
    end
endmodule
